// ---- smr_map.sv ----
// Notes on behaviour
// - System register nibbles live at data addresses 74H to 7FH.
// - Ordinary data-memory accesses reach system registers like any nibble.
// - Writes to fixed-zero bits are dropped; those bits stay 0.
// - Reads of fixed-zero bits always return 0.
// - Incrementing full pointer or index wraps all bits to 0.
// - One full row of sixteen nibbles forms the general register block.
// - General register row comes from a three-bit row pointer, rows 0-7.
// - One operation combines a general register nibble with a data nibble.
module smr_map
  import smr_pkg::*;
(
  input  logic                 clk_sys,
  input  logic                 sys_rst,
  input  logic                 acc_rd,
  input  logic                 acc_wr,
  input  logic [SMR_AW-1:0]    acc_addr,
  input  logic [SMR_DW-1:0]    acc_wdata,
  output logic [SMR_DW-1:0]    rd_data_q,
  input  logic                 op_valid,
  input  smr_op_e              op_code,
  input  logic [SMR_AW-1:0]    op_dm_addr,
  input  logic [SMR_COL_W-1:0] op_reg_col,
  input  logic                 op_to_reg,
  output logic [SMR_DW-1:0]    op_result_q,
  input  logic                 inc_ptr,
  input  logic                 inc_idx,
  output logic [SMR_ROW_W-1:0] general_row_pointer
);

  // ==========================================================
  // Storage
  logic [SMR_DW-1:0] mem_q [SMR_NIBBLES];
  logic [SMR_DW-1:0] mem_d [SMR_NIBBLES];
  logic [SMR_DW-1:0] rd_data_d;
  logic [SMR_DW-1:0] op_result_d;

  function automatic logic [3:0] valid_mask(input logic [6:0] a);
    logic [6:0] off;
    off = a - SMR_SYS_LO;
    if (a >= SMR_SYS_LO) begin
      valid_mask = SMR_VALID_MASK[{off[3:0], 2'b00} +: 4];
    end else begin
      valid_mask = SMR_NIB_ONES;
    end
  endfunction

  // Hole is not physically present: writes vanish, reads give 0
  function automatic logic installed(input logic [6:0] a);
    installed = (a < SMR_HOLE_LO) || (a > SMR_HOLE_HI);
  endfunction

  // ==========================================================
  // Operand fetch
  logic [SMR_ROW_W-1:0] row;
  logic [SMR_AW-1:0]    reg_addr;
  logic [3:0]           dm_val;
  logic [3:0]           reg_val;
  logic [3:0]           status;
  logic [3:0]           alu_res;
  logic                 alu_carry;
  logic                 alu_arith;
  logic [15:0]          ptr_valid;
  logic [15:0]          ptr_next;
  logic [11:0]          idx_valid;
  logic [11:0]          idx_next;

  assign row     = mem_q[SMR_ROWP_LO][SMR_ROW_LSB +: SMR_ROW_W];
  assign reg_addr = {row, op_reg_col};
  assign dm_val   = mem_q[op_dm_addr];
  assign reg_val  = mem_q[reg_addr];
  assign status   = mem_q[SMR_STATUS];

  smr_alu u_alu (
    .op    (op_code),
    .a     (op_to_reg ? reg_val : dm_val),
    .b     (op_to_reg ? dm_val : reg_val),
    .bcd   (mem_q[SMR_ROWP_LO][SMR_BCD_BIT]),
    .res   (alu_res),
    .carry (alu_carry),
    .arith (alu_arith)
  );

  assign ptr_valid = {valid_mask(SMR_PTR_NIB3), valid_mask(SMR_PTR_NIB2),
                      valid_mask(SMR_ADDRESS_POINTER_NIBBLE_ONE),
                      valid_mask(SMR_PTR_NIB0)};
  assign idx_valid = {valid_mask(SMR_IDX_HI), valid_mask(SMR_IDX_MID),
                      valid_mask(SMR_IDX_LO)};
  // Valid bits are contiguous from bit 0, so masking the sum wraps
  assign ptr_next  = ({mem_q[SMR_PTR_NIB3], mem_q[SMR_PTR_NIB2],
                       mem_q[SMR_ADDRESS_POINTER_NIBBLE_ONE],
                       mem_q[SMR_PTR_NIB0]} + 16'h0001) & ptr_valid;
  assign idx_next  = ({mem_q[SMR_IDX_HI], mem_q[SMR_IDX_MID],
                       mem_q[SMR_IDX_LO]} + 12'h001) & idx_valid;

  // ==========================================================
  // Next state; host write wins over operation wins over increment
  always_comb begin
    logic [3:0]        status_n;
    logic [SMR_AW-1:0] dst;
    status_n    = status;
    dst         = op_to_reg ? reg_addr : op_dm_addr;
    mem_d       = mem_q;
    rd_data_d   = rd_data_q;
    op_result_d = op_result_q;
    if (acc_rd) begin
      rd_data_d = mem_q[acc_addr] & valid_mask(acc_addr);
    end
    if (acc_wr) begin
      if (installed(acc_addr)) begin
        mem_d[acc_addr] = acc_wdata & valid_mask(acc_addr);
      end
    end else if (op_valid) begin
      op_result_d = alu_res;
      if (alu_arith) begin
        status_n[SMR_CARRY_BIT] = alu_carry;
        if (alu_res != SMR_NIB_ZERO) begin
          status_n[SMR_Z_BIT] = 1'b0;
        end else if (!status[SMR_CMPR_BIT]) begin
          status_n[SMR_Z_BIT] = 1'b1;
        end
      end
      mem_d[SMR_STATUS] = status_n;
      // Compare mode keeps arithmetic results out of memory
      if (!(alu_arith && status[SMR_CMPR_BIT]) && installed(dst)) begin
        mem_d[dst] = alu_res & valid_mask(dst);
      end
    end else begin
      if (inc_ptr) begin
        mem_d[SMR_PTR_NIB3]                   = ptr_next[15:12];
        mem_d[SMR_PTR_NIB2]                   = ptr_next[11:8];
        mem_d[SMR_ADDRESS_POINTER_NIBBLE_ONE] = ptr_next[7:4];
        mem_d[SMR_PTR_NIB0]                   = ptr_next[3:0];
      end
      if (inc_idx) begin
        mem_d[SMR_IDX_HI]  = idx_next[11:8];
        mem_d[SMR_IDX_MID] = idx_next[7:4];
        mem_d[SMR_IDX_LO]  = idx_next[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < SMR_NIBBLES; i++) begin
        mem_q[i] <= 4'h0;
      end
      rd_data_q   <= 4'h0;
      op_result_q <= 4'h0;
    end else begin
      mem_q       <= mem_d;
      rd_data_q   <= rd_data_d;
      op_result_q <= op_result_d;
    end
  end

  assign general_row_pointer = row;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_ptr_full;
    inc_ptr && !acc_wr && !op_valid && ((ptr_next == 16'h0000));
  endsequence

  sequence s_idx_full;
    inc_idx && !acc_wr && !op_valid && (idx_next == 12'h000);
  endsequence

  sequence s_move_to_reg;
    op_valid && !acc_wr && op_code == SMR_OP_MOV && op_to_reg &&
      installed(reg_addr);
  endsequence

  // Write, one quiet cycle, then a read of the same nibble
  sequence s_write_gap_read;
    acc_wr && acc_addr == SMR_ADDRESS_POINTER_NIBBLE_ONE ##1
      !acc_wr && !op_valid && !inc_ptr ##1
      acc_rd && acc_addr == SMR_ADDRESS_POINTER_NIBBLE_ONE && !acc_wr;
  endsequence

  AST_FIXED_READ_ZERO: assert property (
    acc_rd && acc_addr == SMR_ROWP_HI |=> rd_data_q == 4'h0)
    else $error("fixed-zero nibble read nonzero");

  AST_FIXED_WRITE_DROP: assert property (
    acc_wr && acc_addr == SMR_BANK |=> mem_q[SMR_BANK] == 4'h0)
    else $error("fixed-zero nibble took a write");

  AST_IDX_HI_MASK: assert property (
    acc_wr && acc_addr == SMR_IDX_HI
      |=> mem_q[SMR_IDX_HI] == ($past(acc_wdata) & 4'h1))
    else $error("index high nibble mask wrong");

  AST_SYS_WRITE_READ: assert property (
    s_write_gap_read |=> rd_data_q == $past(acc_wdata, 3))
    else $error("system nibble did not hold written value");

  AST_PTR_WRAP: assert property (
    s_ptr_full |=> mem_q[SMR_ADDRESS_POINTER_NIBBLE_ONE] == 4'h0 &&
      mem_q[SMR_PTR_NIB0] == 4'h0)
    else $error("address pointer did not wrap");

  AST_IDX_WRAP: assert property (
    s_idx_full |=> {mem_q[SMR_IDX_HI], mem_q[SMR_IDX_MID],
                    mem_q[SMR_IDX_LO]} == 12'h000)
    else $error("index did not wrap");

  AST_REG_MOVE: assert property (
    s_move_to_reg |=> mem_q[$past(reg_addr)] ==
      ($past(dm_val) & valid_mask($past(reg_addr))))
    else $error("transfer to general register lost");

  AST_COMPARE_NO_STORE: assert property (
    op_valid && !acc_wr && op_code == SMR_OP_ADD && !op_to_reg &&
      status[SMR_CMPR_BIT] && op_dm_addr != SMR_STATUS
      |=> mem_q[$past(op_dm_addr)] == $past(dm_val))
    else $error("compare mode stored a result");

  AST_ROW_FROM_PTR: assert property (
    acc_wr && acc_addr == SMR_ROWP_LO ##1 !acc_wr
      |-> general_row_pointer == $past(acc_wdata[3:1]))
    else $error("row pointer not taken from its field");

  AST_HOLE_EMPTY: assert property (
    acc_wr && !installed(acc_addr) |=> mem_q[$past(acc_addr)] == 4'h0)
    else $error("uninstalled nibble took a write");

endmodule

// ---- smr_pkg.sv ----
package smr_pkg;

  // ==========================================================
  // Data memory geometry
  localparam int SMR_AW        = 7;
  localparam int SMR_DW        = 4;
  localparam int SMR_NIBBLES   = 128;
  localparam int SMR_ROW_W     = 3;
  localparam int SMR_COL_W     = 4;

  // ==========================================================
  // System register area
  localparam logic [6:0] SMR_SYS_LO        = 7'h74;
  localparam logic [6:0] SMR_SYS_HI        = 7'h7F;
  localparam logic [6:0] SMR_PTR_NIB3      = 7'h74;
  localparam logic [6:0] SMR_PTR_NIB2      = 7'h75;
  localparam logic [6:0] SMR_ADDRESS_POINTER_NIBBLE_ONE = 7'h76;
  localparam logic [6:0] SMR_PTR_NIB0      = 7'h77;
  localparam logic [6:0] SMR_WINDOW        = 7'h78;
  localparam logic [6:0] SMR_BANK          = 7'h79;
  localparam logic [6:0] SMR_IDX_HI        = 7'h7A;
  localparam logic [6:0] SMR_IDX_MID       = 7'h7B;
  localparam logic [6:0] SMR_IDX_LO        = 7'h7C;
  localparam logic [6:0] SMR_ROWP_HI       = 7'h7D;
  localparam logic [6:0] SMR_ROWP_LO       = 7'h7E;
  localparam logic [6:0] SMR_STATUS        = 7'h7F;

  // Uninstalled hole in data memory
  localparam logic [6:0] SMR_HOLE_LO       = 7'h40;
  localparam logic [6:0] SMR_HOLE_HI       = 7'h6E;

  // Writable-bit masks for 74H..7FH, nibble 0 is 74H
  localparam logic [47:0] SMR_VALID_MASK   = 48'hFF0F_F10F_FF00;

  // ==========================================================
  // Field positions
  localparam int SMR_ROW_LSB   = 1;
  localparam int SMR_BCD_BIT   = 0;
  localparam int SMR_IDXEN_BIT = 0;
  localparam int SMR_Z_BIT     = 1;
  localparam int SMR_CARRY_BIT = 2;
  localparam int SMR_CMPR_BIT  = 3;

  localparam logic [3:0] SMR_NIB_ZERO = 4'h0;
  localparam logic [3:0] SMR_NIB_ONES = 4'hF;
  localparam logic [3:0] SMR_BCD_MAX  = 4'h9;
  localparam logic [4:0] SMR_BCD_ADJ  = 5'h06;

  typedef enum logic [2:0] {
    SMR_OP_MOV = 3'h0,
    SMR_OP_ADD = 3'h1,
    SMR_OP_SUB = 3'h3,
    SMR_OP_AND = 3'h2,
    SMR_OP_OR  = 3'h6,
    SMR_OP_XOR = 3'h7
  } smr_op_e;

endpackage

// ---- smr_alu.sv ----
module smr_alu
  import smr_pkg::*;
(
  input  smr_op_e    op,
  input  logic [3:0] a,
  input  logic [3:0] b,
  input  logic       bcd,
  output logic [3:0] res,
  output logic       carry,
  output logic       arith
);

  logic [4:0] raw;

  // ==========================================================
  // Nibble operation, a is the destination operand
  always_comb begin
    raw   = 5'h00;
    res   = 4'h0;
    carry = 1'b0;
    arith = 1'b0;
    unique case (op)
      SMR_OP_ADD: begin
        arith = 1'b1;
        raw   = {1'b0, a} + {1'b0, b};
        if (bcd && (raw[4] || raw[3:0] > SMR_BCD_MAX)) begin
          raw   = raw + SMR_BCD_ADJ;
          carry = 1'b1;
        end else begin
          carry = raw[4];
        end
        res = raw[3:0];
      end
      SMR_OP_SUB: begin
        arith = 1'b1;
        raw   = {1'b0, a} - {1'b0, b};
        carry = raw[4];
        // Decimal borrow pulls six out of the low digit
        if (bcd && raw[4]) begin
          raw = raw - SMR_BCD_ADJ;
        end
        res = raw[3:0];
      end
      SMR_OP_AND: res = a & b;
      SMR_OP_OR:  res = a | b;
      SMR_OP_XOR: res = a ^ b;
      SMR_OP_MOV: res = b;
    endcase
  end

endmodule

// ---- smr_core_model.sv ----
module smr_core_model
  import smr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [3:0]  rd_data_q,
  input  wire logic [3:0]  op_result_q,
  output logic             acc_rd,
  output logic             acc_wr,
  output logic [6:0]       acc_addr,
  output logic [3:0]       acc_wdata,
  output logic             op_valid,
  output smr_op_e          op_code,
  output logic [6:0]       op_dm_addr,
  output logic [3:0]       op_reg_col,
  output logic             op_to_reg,
  output logic             inc_ptr,
  output logic             inc_idx
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle values; released address and data buses show inverted data, not the last value
  initial begin
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_addr = 7'h00;
    acc_wdata = 4'h0;
    op_valid = 1'b0;
    op_code = SMR_OP_MOV;
    op_dm_addr = 7'h00;
    op_reg_col = 4'h0;
    op_to_reg = 1'b0;
    inc_ptr = 1'b0;
    inc_idx = 1'b0;
  end

  // ==========================================================
  // Core requests, one cycle each
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge clk_sys);
    acc_wr <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [3:0] d);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_rd <= 1'b1;
    @(posedge clk_sys);
    acc_rd <= 1'b0;
    acc_addr <= ~a;
    @(posedge clk_sys);
    #1 d = rd_data_q;
  endtask

  // Destination is the row nibble when to_reg is set, else dm
  task automatic op(input smr_op_e c, input logic [6:0] dm,
                    input logic [3:0] col, input logic to_reg,
                    output logic [3:0] res);
    @(posedge clk_sys);
    op_code <= c;
    op_dm_addr <= dm;
    op_reg_col <= col;
    op_to_reg <= to_reg;
    op_valid <= 1'b1;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    op_dm_addr <= ~dm;
    op_reg_col <= ~col;
    @(posedge clk_sys);
    #1 res = op_result_q;
  endtask

  task automatic inc(input logic p, input logic i);
    @(posedge clk_sys);
    inc_ptr <= p;
    inc_idx <= i;
    @(posedge clk_sys);
    inc_ptr <= 1'b0;
    inc_idx <= 1'b0;
  endtask
endmodule

// ---- system_and_general_register_map_tb.sv ----
module system_and_general_register_map_tb
  import smr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       acc_rd, acc_wr, op_valid, op_to_reg, inc_ptr, inc_idx;
  logic [6:0] acc_addr, op_dm_addr;
  logic [3:0] acc_wdata, op_reg_col, rd_data_q, op_result_q, v;
  logic [2:0] general_row_pointer;
  smr_op_e    op_code;
  int         err_count = 0;
  int         n_compared = 0;
  smr_op_e    codes [6] = '{SMR_OP_MOV, SMR_OP_ADD, SMR_OP_SUB,
                            SMR_OP_AND, SMR_OP_OR, SMR_OP_XOR};
  logic [3:0] op_exp [6] = '{4'hA, 4'h6, 4'h2, 4'h8, 4'hE, 4'h6};
  logic [6:0] ho_addr [4] = '{7'h3F, 7'h40, 7'h6E, 7'h6F};
  logic [3:0] ho_exp [4] = '{4'h5, 4'h0, 4'h0, 4'h5};

  always #4 clk_sys = ~clk_sys;

  smr_map smr_map_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .rd_data_q(rd_data_q), .op_valid(op_valid), .op_code(op_code),
    .op_dm_addr(op_dm_addr), .op_reg_col(op_reg_col), .op_to_reg(op_to_reg),
    .op_result_q(op_result_q), .inc_ptr(inc_ptr), .inc_idx(inc_idx),
    .general_row_pointer(general_row_pointer));

  smr_core_model core_i (.clk_sys(clk_sys), .rd_data_q(rd_data_q),
    .op_result_q(op_result_q), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .op_valid(op_valid),
    .op_code(op_code), .op_dm_addr(op_dm_addr), .op_reg_col(op_reg_col),
    .op_to_reg(op_to_reg), .inc_ptr(inc_ptr), .inc_idx(inc_idx));

  // ==========================================================
  // Comparison and verdict
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr_rd(input logic [6:0] a, input logic [3:0] d);
    core_i.wr(a, d);
    core_i.rd(a, v);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    core_i.rd(SMR_ADDRESS_POINTER_NIBBLE_ONE, v);
    check(v, 4'h0);
    check({1'b0, general_row_pointer}, 4'h0);
    // Every system nibble: ones written, only valid bits come back
    for (int i = 0; i < 12; i++) begin
      wr_rd(SMR_SYS_LO + 7'(i), 4'hF);
      check(v, SMR_VALID_MASK[i*4 +: 4]);
      if (SMR_SYS_LO + 7'(i) == SMR_ROWP_LO)
        check({1'b0, general_row_pointer}, 4'h7);
      core_i.wr(SMR_SYS_LO + 7'(i), 4'h0);
    end
    // Edges of the uninstalled hole
    for (int i = 0; i < 4; i++) begin
      wr_rd(ho_addr[i], 4'h5);
      check(v, ho_exp[i]);
    end
    // Pointer: full wrap, then carry between nibbles
    core_i.wr(SMR_ADDRESS_POINTER_NIBBLE_ONE, 4'hF);
    core_i.wr(SMR_PTR_NIB0, 4'hF);
    core_i.inc(1'b1, 1'b0);
    core_i.rd(SMR_ADDRESS_POINTER_NIBBLE_ONE, v);
    check(v, 4'h0);
    core_i.rd(SMR_PTR_NIB0, v);
    check(v, 4'h0);
    core_i.wr(SMR_PTR_NIB0, 4'hF);
    core_i.inc(1'b1, 1'b0);
    core_i.rd(SMR_ADDRESS_POINTER_NIBBLE_ONE, v);
    check(v, 4'h1);
    // Index: all nine valid bits set, wraps to zero
    core_i.wr(SMR_IDX_HI, 4'h1);
    core_i.wr(SMR_IDX_MID, 4'hF);
    core_i.wr(SMR_IDX_LO, 4'hF);
    core_i.inc(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      core_i.rd(SMR_IDX_HI + 7'(i), v);
      check(v, 4'h0);
    end
    core_i.inc(1'b1, 1'b1);
    core_i.rd(SMR_PTR_NIB0, v);
    check(v, 4'h1);
    core_i.rd(SMR_IDX_LO, v);
    check(v, 4'h1);
    // General row 2: column 5 sits at 25H; rows 4 to 6 never chosen
    core_i.wr(SMR_ROWP_LO, 4'h4);
    // Let the write settle before looking at the pointer
    #1;
    check({1'b0, general_row_pointer}, 4'h2);
    for (int i = 0; i < 6; i++) begin
      core_i.wr(7'h10, 4'hC);
      core_i.wr(7'h25, 4'hA);
      core_i.op(codes[i], 7'h10, 4'h5, 1'b0, v);
      check(v, op_exp[i]);
      core_i.rd(7'h10, v);
      check(v, op_exp[i]);
    end
    // 10H still holds the last result, which moves into the row
    core_i.op(SMR_OP_MOV, 7'h10, 4'h5, 1'b1, v);
    check(v, op_exp[5]);
    core_i.rd(7'h25, v);
    check(v, op_exp[5]);
    // Compare mode: sum not stored, carry still raised
    core_i.wr(SMR_STATUS, 4'h8);
    core_i.wr(7'h10, 4'hC);
    core_i.op(SMR_OP_ADD, 7'h10, 4'h5, 1'b0, v);
    check(v, 4'h2);
    core_i.rd(7'h10, v);
    check(v, 4'hC);
    core_i.rd(SMR_STATUS, v);
    check(v, 4'hC);
    // Decimal add: 8 plus 6 gives digit 4 and a carry
    core_i.wr(SMR_STATUS, 4'h0);
    core_i.wr(SMR_ROWP_LO, 4'h5);
    core_i.wr(7'h10, 4'h8);
    core_i.op(SMR_OP_ADD, 7'h10, 4'h5, 1'b0, v);
    check(v, 4'h4);
    core_i.rd(7'h10, v);
    check(v, 4'h4);
    core_i.rd(SMR_STATUS, v);
    check(v, 4'h4);
    give_verdict();
  end
endmodule
